// ---- mhp_host_model.sv ----
// microprocessor model for the muxed host port
`timescale 1ns/100ps
module mhp_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_dev_bus,
  input wire logic i_dev_oe,
  output logic o_port_select_n,
  output logic o_read_enable_n,
  output logic o_write_strobe_n,
  output logic o_reg_select,
  output logic [7:0] o_bus
);
  logic [7:0] drv = 8'h00;
  logic on = 1'b0;
  initial {o_port_select_n, o_read_enable_n, o_write_strobe_n, o_reg_select} = 4'he;
  // released bus shows the inverse of the last value, so stale data never matches
  always_comb o_bus = i_dev_oe ? i_dev_bus : (on ? drv : ~drv);
  // one access; late_cs makes select the timing strobe
  task automatic xfer(input logic a, input logic [7:0] d, input logic wr, input logic late_cs,
                      output logic [7:0] q);
    @(negedge i_clk);
    o_reg_select = a;
    drv = d;
    on = wr;
    repeat (3) @(negedge i_clk);
    if (!late_cs) o_port_select_n = 1'b0;
    if (wr) o_write_strobe_n = 1'b0;
    else o_read_enable_n = 1'b0;
    @(negedge i_clk);
    o_port_select_n = 1'b0;
    repeat (4) @(negedge i_clk);
    q = o_bus;
    {o_port_select_n, o_read_enable_n, o_write_strobe_n} = 3'h7;
    on = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask
endmodule

// ---- mhp_host_port.sv ----
// muxed 8-bit parallel host port, device side
`timescale 1ns/100ps
`include "mhp_map.svh"
module mhp_host_port
  import mhp_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int NUM_REGS = 256
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_host_port_select_n,
  input wire logic i_host_read_enable_n,
  input wire logic i_host_write_strobe_n,
  input wire logic i_host_reg_select,
  input wire logic [DATA_W-1:0] i_host_shared_bus,
  output logic [DATA_W-1:0] o_host_shared_bus,
  output logic o_host_shared_bus_oe,
  output logic [DATA_W-1:0] o_reg_index,
  output logic o_reg_wr,
  output logic [DATA_W-1:0] o_reg_wdata
);
  localparam int IDX_W = $clog2(NUM_REGS);

  // how an access flows through the port:
  //   the host pins pass two flops before any decision is made, so a write lands
  //   on the third clock edge after the later of select and strobe falls
  //   the bus drive enable is the only path taken straight from the pins, since
  //   the host expects the bus released as soon as select or read enable rises
  //   read data is refreshed every enabled edge, so it trails the pins by three edges
  //   and a host must keep its strobes low for at least four clocks
  //   the index never steps on its own; each data access reuses the last index written

  // the index register must be able to address every host register, with no holes
  if (DATA_W != 8 || NUM_REGS < 2 || NUM_REGS > (1 << DATA_W) ||
      (1 << IDX_W) != NUM_REGS) begin : g_bad_params
    $error("mhp_host_port: DATA_W must be 8, NUM_REGS a power of two within 2..256");
  end

  // two-stage synchronisers; stage one is read only by stage two
  // the bus word needs no gray code: the host holds it steady from three clocks
  // before the strobe, so both stages carry one settled value when it is used
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [DATA_W-1:0] bus1;
  logic [DATA_W-1:0] bus2;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= `MHP_SYNC_RST;
      sync2 <= `MHP_SYNC_RST;
      bus1 <= '0;
      bus2 <= '0;
    end else if (i_ce) begin
      sync1 <= {i_host_port_select_n, i_host_read_enable_n, i_host_write_strobe_n,
                ~i_host_reg_select};
      sync2 <= sync1;
      bus1 <= i_host_shared_bus;
      bus2 <= bus1;
    end
  end

  logic sel_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic is_index_s;
  // synchronised copies of the pins, idle after reset so no false access follows it
  assign sel_n_s = sync2[`MHP_BIT_SEL];
  assign rd_n_s = sync2[`MHP_BIT_RD];
  assign wr_n_s = sync2[`MHP_BIT_WR];
  assign is_index_s = ~sync2[`MHP_BIT_IDX];

  // an access is live once both select and strobe are low, whichever fell last
  logic wr_act;
  logic rd_act;
  assign wr_act = !sel_n_s && !wr_n_s;
  assign rd_act = !sel_n_s && !rd_n_s;

  mhp_state_t state;
  mhp_state_t next_state;
  logic [DATA_W-1:0] index;
  logic [DATA_W-1:0] next_index;
  logic [DATA_W-1:0] regs [NUM_REGS];
  logic wr_go;

  // one write per strobe: store happens on entry to the write state
  // a strobe held low for many clocks stays in the write state and stores nothing more
  // when write and read strobes are both low the write wins
  always_comb begin
    next_state = state;
    next_index = index;
    wr_go = 1'b0;
    case (state)
      MHP_IDLE: begin
        if (wr_act) begin
          next_state = MHP_WRITE;
          if (is_index_s == `MHP_SEL_INDEX) begin
            next_index = bus2;
          end else begin
            wr_go = 1'b1;
          end
        end else if (rd_act) begin
          next_state = MHP_READ;
        end
      end
      MHP_WRITE: begin
        if (!wr_act) next_state = MHP_IDLE;
      end
      MHP_READ: begin
        if (!rd_act) next_state = MHP_IDLE;
      end
      default: next_state = MHP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= MHP_IDLE;
      index <= `MHP_INDEX_RST;
    end else if (i_ce) begin
      state <= next_state;
      index <= next_index;
    end
  end

  // host register array, one entry per index value
  // written on the same edge that raises the write notice
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        regs[g] <= `MHP_DATA_RST;
      end else if (i_ce && wr_go && index[IDX_W-1:0] == IDX_W'(g)) begin
        regs[g] <= bus2;
      end
    end
  end

  // write notice and read data, registered; written value stands until the next write
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] next_wdata;
  always_comb begin
    next_rdata = (is_index_s == `MHP_SEL_INDEX) ? index : regs[index[IDX_W-1:0]];
    next_wdata = wr_go ? bus2 : o_reg_wdata;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_host_shared_bus <= '0;
      o_reg_wr <= 1'b0;
      o_reg_wdata <= '0;
    end else if (i_ce) begin
      o_host_shared_bus <= next_rdata;
      o_reg_wr <= wr_go;
      o_reg_wdata <= next_wdata;
    end
  end

  // enable is direct from pins so the bus releases without clock delay
  assign o_host_shared_bus_oe = !i_host_port_select_n && !i_host_read_enable_n;
  assign o_reg_index = index;

  // the drive enable must follow the pins with no clock in between
  oe_match_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_host_shared_bus_oe == (!i_host_port_select_n && !i_host_read_enable_n))
    else $error("bus drive does not follow select and read enable");
  // write steps: a live write in idle, one notice for a data write, then wait for the strobe to rise
  sequence s_wr_go;
    state == MHP_IDLE && wr_act && i_ce;
  endsequence
  sequence s_wr_data;
    state == MHP_IDLE && wr_act && is_index_s == `MHP_SEL_DATA && i_ce;
  endsequence
  write_enter_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_wr_go |=> state == MHP_WRITE)
    else $error("write not entered");
  data_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_wr_data |=> o_reg_wr && o_reg_wdata == $past(bus2))
    else $error("data write not reported");
  idx_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state == MHP_IDLE && wr_act && is_index_s && i_ce |=> index == $past(bus2))
    else $error("index write lost");
  one_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_reg_wr && $past(i_ce) |-> !$past(o_reg_wr))
    else $error("double write from one strobe");
  wr_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_reg_wr && i_ce |=> !o_reg_wr)
    else $error("write notice longer than one cycle");
  hold_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state == MHP_WRITE && wr_act && i_ce |=> state == MHP_WRITE && !o_reg_wr)
    else $error("held strobe wrote again");
  write_exit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state == MHP_WRITE && !wr_act && i_ce |=> state == MHP_IDLE)
    else $error("write state not left");
  wdata_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_reg_wr |-> $stable(o_reg_wdata))
    else $error("written value changed without a write");
  no_select_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sel_n_s && i_ce |=> !o_reg_wr)
    else $error("write without select");
  // with the clock enable low the state, index and read data may not move
  freeze_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_ce |=> $stable(state) && $stable(index) && $stable(o_host_shared_bus))
    else $error("state moved while the clock enable was low");
  // read steps: the bus word follows the synchronised register select one edge later
  sequence s_rd_data;
    i_ce && is_index_s == `MHP_SEL_DATA;
  endsequence
  index_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && is_index_s |=> o_host_shared_bus == $past(index))
    else $error("index readback wrong");
  data_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_rd_data |=> o_host_shared_bus == $past(regs[index[IDX_W-1:0]]))
    else $error("data readback wrong");
  read_state_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state == MHP_IDLE && rd_act && !wr_act && i_ce |=> state == MHP_READ)
    else $error("read not entered");
  read_exit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state == MHP_READ && !rd_act && i_ce |=> state == MHP_IDLE)
    else $error("read state not left");
  // the index changes only through an index write; a data write lands in the indexed register
  index_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $changed(index) |-> $past(state == MHP_IDLE && wr_act && is_index_s && i_ce))
    else $error("index moved without an index write");
  reg_store_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_reg_wr |-> regs[index[IDX_W-1:0]] == o_reg_wdata)
    else $error("data write missed the indexed register");
endmodule

// ---- mhp_map.svh ----
// constants for the muxed 8-bit host port
// Notes on behaviour
// - one 8-bit bidirectional bus carries both register index and register data
// - register select high picks the index register, low picks the data register
// - port select is active low; host holds it low for every access
// - read enable is active low; low asks device to drive register contents
// - write strobe is active low; low with bus data stores selected register
// - device drives bus only while port select and read enable are both low
// - strobe-timed and select-timed access both work; later falling signal starts access
`ifndef MHP_MAP_SVH
`define MHP_MAP_SVH
`define MHP_SEL_INDEX 1'b1
`define MHP_SEL_DATA 1'b0
`define MHP_INDEX_RST 8'h00
`define MHP_DATA_RST 8'h00
`define MHP_SYNC_RST 4'hf
`define MHP_BIT_SEL 2'h3
`define MHP_BIT_RD 2'h2
`define MHP_BIT_WR 2'h1
`define MHP_BIT_IDX 2'h0
`endif

// ---- mhp_pkg.sv ----
// types for the muxed 8-bit host port
package mhp_pkg;
  typedef enum logic [1:0] {MHP_IDLE, MHP_WRITE, MHP_READ} mhp_state_t;
endpackage

// ---- muxed_8bit_host_port_test.sv ----
// self-checking bench for the muxed host port
`timescale 1ns/100ps
module muxed_8bit_host_port_test;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic ce = 1'b1;
  logic cs_n, oe_n, we_n, sel, oe, wr;
  logic [7:0] bus, dout, idx, wd, q;
  int err_total = 0;
  int compares = 0;
  int wr_n = 0;
  always #25 i_clk = ~i_clk;
  mhp_host_port dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
    .i_host_port_select_n(cs_n), .i_host_read_enable_n(oe_n), .i_host_write_strobe_n(we_n),
    .i_host_reg_select(sel), .i_host_shared_bus(bus), .o_host_shared_bus(dout),
    .o_host_shared_bus_oe(oe), .o_reg_index(idx), .o_reg_wr(wr), .o_reg_wdata(wd));
  mhp_host_model u_host (.i_clk(i_clk), .i_dev_bus(dout), .i_dev_oe(oe),
    .o_port_select_n(cs_n), .o_read_enable_n(oe_n), .o_write_strobe_n(we_n),
    .o_reg_select(sel), .o_bus(bus));
  // count write pulses to prove each is exactly one cycle per access
  always @(posedge i_clk) if (wr === 1'b1) wr_n++;
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic close_out;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_write;
    u_host.xfer(1'b1, 8'ha5, 1'b1, 1'b0, q);
    chk(idx === 8'ha5, "index");
    wr_n = 0;
    u_host.xfer(1'b0, 8'h3c, 1'b1, 1'b1, q);
    chk(wr_n == 1 && wd === 8'h3c, "data write");
  endtask
  task automatic t_read;
    u_host.xfer(1'b0, 8'h3c, 1'b0, 1'b0, q);
    chk(q === 8'h3c, "data read");
    u_host.xfer(1'b1, 8'ha5, 1'b0, 1'b1, q);
    chk(q === 8'ha5 && oe === 1'b0, "index read");
    u_host.xfer(1'b1, 8'h07, 1'b1, 1'b0, q);
    u_host.xfer(1'b0, 8'h00, 1'b0, 1'b0, q);
    chk(q === 8'h00 && wd === 8'h3c, "fresh reg");
  endtask
  // with the clock enable low, strobes must leave index, registers and notices alone
  task automatic t_freeze;
    wr_n = 0;
    ce = 1'b0;
    u_host.xfer(1'b1, 8'h5a, 1'b1, 1'b0, q);
    u_host.xfer(1'b0, 8'h99, 1'b1, 1'b1, q);
    ce = 1'b1;
    u_host.xfer(1'b0, 8'h00, 1'b0, 1'b0, q);
    chk(q === 8'h00 && idx === 8'h07 && wd === 8'h3c && wr_n == 0, "frozen write");
  endtask
  initial begin
    repeat (16) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_write();
    t_read();
    t_freeze();
    close_out();
  end
  // watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    close_out();
  end
endmodule
